//--- rtl/fbwd_pkg.sv
// shared constants for the fieldbus watchdog and operation-mode block
package fbwd_pkg;
  // register offsets, byte addresses in the slave register space
  localparam logic [11:0] wd_multiplier_addr = 12'h400;
  localparam logic [11:0] host_wd_time_addr  = 12'h410;
  localparam logic [11:0] pd_wd_time_addr    = 12'h420;
  // reset values
  localparam logic [15:0] wd_multiplier_rst  = 16'h0000;
  localparam logic [15:0] host_wd_time_rst   = 16'h0000;
  localparam logic [15:0] pd_wd_time_rst     = 16'h0000;
  // process data object indices
  localparam logic [15:0] profile_rx_object  = 16'h1600;
  localparam logic [15:0] profile_tx_object  = 16'h1a00;
  // object index of the mode-select entry
  localparam logic [15:0] mode_select_object = 16'h6060;
  // mode codes as written to the mode-select object
  localparam logic [7:0]  mode_code_profile  = 8'h02;
  localparam logic [7:0]  mode_code_bypass   = 8'h00;
  // identity defaults, values are arbitrary
  localparam logic [31:0] vendor_id_dflt     = 32'h0000_0a5a;
  localparam logic [31:0] product_code_dflt  = 32'h0000_1234;
  localparam logic [31:0] revision_dflt      = 32'h0000_0002;
  // operation modes
  typedef enum logic [0:0] {
    mode_profile = 1'b0,
    mode_bypass  = 1'b1
  } op_mode_e;
  // watchdog state machine
  typedef enum logic [1:0] {
    wd_idle    = 2'b00,
    wd_running = 2'b01,
    wd_expired = 2'b10
  } wd_state_e;
endpackage : fbwd_pkg

//--- rtl/fbwd_tick.sv
// prescaler that turns the multiplier setting into watchdog tick pulses
`timescale 1ns/10ps
module fbwd_tick
  import fbwd_pkg::*;
#(
  parameter int width = 16
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             restart,
  input  wire logic [width-1:0] divide,
  output logic                  tick
);
  logic [width-1:0] count;

  // refuse widths too narrow for the prescaler, checked at elaboration
  if (width < 2) begin : g_width_check
    $error("fbwd_tick width must be at least 2");
  end

  // one tick every divide+1 clocks, realigned on restart
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (restart) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count >= divide) begin
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + {{(width-1){1'b0}}, 1'b1};
      tick  <= 1'b0;
    end
  end
endmodule : fbwd_tick

//--- rtl/fbwd_mode.sv
// process-data watchdog, timeout fault and operation-mode selection
`timescale 1ns/10ps
module fbwd_mode
  import fbwd_pkg::*;
#(
  parameter logic [31:0] vendor_id = vendor_id_dflt // arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  // slave register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [11:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_ack,
  // process data traffic
  input  wire logic        pd_exchange_ok,
  // object writes from the master
  input  wire logic        obj_wr,
  input  wire logic [15:0] obj_index,
  input  wire logic [7:0]  obj_wdata,
  // process data assignment
  input  wire logic        pdo_assign_wr,
  input  wire logic        pdo_rx_profile,
  input  wire logic        pdo_tx_profile,
  // keypad parameter
  input  wire logic        keypad_wr,
  input  wire logic        keypad_mode,
  // identity settings
  input  wire logic        ident_wr,
  input  wire logic [31:0] ident_product,
  input  wire logic [31:0] ident_revision,
  // drive fault reset
  input  wire logic        fault_reset,
  output logic             fieldbus_timeout_fault,
  output logic             op_mode_param,
  output logic             op_mode_monitor,
  output logic             mode_refused,
  output logic      [31:0] vendor_code,
  output logic      [31:0] product_code,
  output logic      [31:0] revision_code
);
  logic [15:0] wd_multiplier;
  logic [15:0] host_wd_time;
  logic [15:0] pd_wd_time;
  logic [15:0] wd_count;
  logic        wd_tick;
  logic        wd_restart;
  logic        profile_assigned;
  wd_state_e   wd_state;
  op_mode_e    op_mode;

  // register writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wd_multiplier <= wd_multiplier_rst;
      host_wd_time  <= host_wd_time_rst;
      pd_wd_time    <= pd_wd_time_rst;
    end else if (reg_wr) begin
      case (reg_addr)
        wd_multiplier_addr: wd_multiplier <= reg_wdata;
        host_wd_time_addr:  host_wd_time  <= reg_wdata;
        pd_wd_time_addr:    pd_wd_time    <= reg_wdata;
        default: ;
      endcase
    end
  end

  // register reads, unmapped reads return zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
      reg_ack   <= 1'b0;
    end else begin
      reg_ack <= reg_rd | reg_wr;
      if (reg_rd) begin
        case (reg_addr)
          wd_multiplier_addr: reg_rdata <= wd_multiplier;
          host_wd_time_addr:  reg_rdata <= host_wd_time;
          pd_wd_time_addr:    reg_rdata <= pd_wd_time;
          default:            reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // restart when traffic arrives or the time setting is rewritten
  assign wd_restart = pd_exchange_ok | (reg_wr && reg_addr == pd_wd_time_addr);

  fbwd_tick #(.width(16)) u_tick (
    .clk     (clk),
    .nrst    (nrst),
    .restart (wd_restart),
    .divide  (wd_multiplier),
    .tick    (wd_tick)
  );

  // watchdog: counts ticks since last good exchange
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wd_state <= wd_idle;
      wd_count <= 16'h0000;
    end else begin
      case (wd_state)
        wd_idle: begin
          wd_count <= 16'h0000;
          if (pd_wd_time != 16'h0000) wd_state <= wd_running;
        end
        wd_running: begin
          if (pd_wd_time == 16'h0000) begin
            wd_state <= wd_idle;
          end else if (wd_restart) begin
            wd_count <= 16'h0000;
          end else if (wd_tick) begin
            if (wd_count + 16'h0001 >= pd_wd_time) begin
              wd_state <= wd_expired;
            end
            wd_count <= wd_count + 16'h0001;
          end
        end
        wd_expired: begin
          wd_count <= 16'h0000;
          if (wd_restart) wd_state <= wd_running;
        end
        default: wd_state <= wd_idle;
      endcase
    end
  end

  // sticky timeout fault; a new expiry beats a simultaneous reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fieldbus_timeout_fault <= 1'b0;
    end else if (wd_state == wd_running && !wd_restart && wd_tick &&
                 pd_wd_time != 16'h0000 && wd_count + 16'h0001 >= pd_wd_time) begin
      fieldbus_timeout_fault <= 1'b1;
    end else if (fault_reset) begin
      fieldbus_timeout_fault <= 1'b0;
    end
  end

  // remembers whether a profile object is in the assignment
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      profile_assigned <= 1'b1;
    end else if (pdo_assign_wr) begin
      profile_assigned <= pdo_rx_profile | pdo_tx_profile;
    end
  end

  // mode selection: in one cycle pdo assignment beats object write beats keypad, else the latest accepted request wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      op_mode      <= mode_profile;
      mode_refused <= 1'b0;
    end else begin
      mode_refused <= 1'b0;
      if (pdo_assign_wr) begin
        if (pdo_rx_profile | pdo_tx_profile) op_mode <= mode_profile;
        else op_mode <= mode_bypass;
      end else if (obj_wr && obj_index == mode_select_object) begin
        if (obj_wdata == mode_code_profile) begin
          if (profile_assigned) op_mode <= mode_profile;
          else mode_refused <= 1'b1;
        end else if (obj_wdata == mode_code_bypass) begin
          op_mode <= mode_bypass;
        end
      end else if (keypad_wr) begin
        if (keypad_mode == mode_bypass) op_mode <= mode_bypass;
        else if (profile_assigned) op_mode <= mode_profile;
        else mode_refused <= 1'b1;
      end
    end
  end

  assign op_mode_param   = op_mode;
  assign op_mode_monitor = op_mode;

  // identity presented to the master
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      product_code  <= product_code_dflt;
      revision_code <= revision_dflt;
    end else if (ident_wr) begin
      product_code  <= ident_product;
      revision_code <= ident_revision;
    end
  end
  assign vendor_code = vendor_id;

  // fault holds until the fault reset
  chk_fault_sticky: assert property (@(posedge clk) disable iff (!nrst)
    fieldbus_timeout_fault && !fault_reset |=> fieldbus_timeout_fault)
    else $error("timeout fault dropped without reset");
  chk_no_wd_fault: assert property (@(posedge clk) disable iff (!nrst)
    pd_wd_time == 16'h0000 && !fieldbus_timeout_fault |=> !fieldbus_timeout_fault)
    else $error("fault raised with watchdog disabled");
  chk_restart_clear: assert property (@(posedge clk) disable iff (!nrst)
    wd_state == wd_running && pd_exchange_ok && pd_wd_time != 16'h0000
    |=> wd_count == 16'h0000)
    else $error("watchdog not restarted");
  chk_expire_fault: assert property (@(posedge clk) disable iff (!nrst)
    $rose(wd_state == wd_expired) |-> fieldbus_timeout_fault)
    else $error("expiry without fault");
  // expiry step: a counted tick that reaches the set time with no restart
  sequence wd_last_tick;
    wd_state == wd_running && wd_tick && !wd_restart && pd_wd_time != 16'h0000 &&
    wd_count + 16'h0001 >= pd_wd_time;
  endsequence
  chk_tick_expiry: assert property (@(posedge clk) disable iff (!nrst)
    wd_last_tick |=> fieldbus_timeout_fault && wd_state == wd_expired)
    else $error("final tick did not expire");
  chk_refuse_profile: assert property (@(posedge clk) disable iff (!nrst)
    mode_refused |-> op_mode_monitor == $past(op_mode_monitor))
    else $error("refused mode applied");
  chk_pdo_profile: assert property (@(posedge clk) disable iff (!nrst)
    pdo_assign_wr && (pdo_rx_profile || pdo_tx_profile) |=> op_mode == mode_profile)
    else $error("profile assign ignored");
  chk_pdo_bypass: assert property (@(posedge clk) disable iff (!nrst)
    pdo_assign_wr && !pdo_rx_profile && !pdo_tx_profile |=> op_mode == mode_bypass)
    else $error("bypass assign ignored");
  chk_obj_bypass: assert property (@(posedge clk) disable iff (!nrst)
    !pdo_assign_wr && obj_wr && obj_index == mode_select_object &&
    obj_wdata == mode_code_bypass |=> op_mode_param == mode_bypass)
    else $error("object write ignored");
  chk_keypad_bypass: assert property (@(posedge clk) disable iff (!nrst)
    !pdo_assign_wr && !obj_wr && keypad_wr && keypad_mode |=> op_mode == mode_bypass)
    else $error("keypad write ignored");
endmodule : fbwd_mode

//--- testbench/fb_master_model.sv
// fieldbus master model: register, process-data and object traffic
`timescale 1ns/10ps
module fb_master_model
  import fbwd_pkg::*;
(
  input  wire logic  clk,
  output logic        reg_wr,
  output logic        reg_rd,
  output logic [11:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic        pd_exchange_ok,
  output logic        obj_wr,
  output logic [15:0] obj_index,
  output logic [7:0]  obj_wdata
);
  // idle bus at time zero
  initial begin
    {reg_wr, reg_rd, pd_exchange_ok, obj_wr} = 4'h0;
    {reg_addr, reg_wdata, obj_index, obj_wdata} = '0;
  end
  // one-cycle access; released address and data show the inverse of the last value, strobes drop to zero
  task automatic access(input logic wr, input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    #10 {reg_wr, reg_rd, reg_addr, reg_wdata} = {wr, !wr, a, d};
    @(posedge clk);
    #10 {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
  endtask : access
  // disable first so a stale time cannot expire mid-setup
  task automatic set_watchdog(input logic [15:0] m, input logic [15:0] t);
    access(1'b1, pd_wd_time_addr, 16'h0000);
    access(1'b1, wd_multiplier_addr, m);
    access(1'b1, pd_wd_time_addr, t);
  endtask : set_watchdog
  // n back-to-back exchanges; silence afterwards models a halted group
  task automatic exchange(input int n);
    @(posedge clk);
    #10 pd_exchange_ok = 1'b1;
    repeat (n) @(posedge clk);
    #10 pd_exchange_ok = 1'b0;
  endtask : exchange
  // object write, mode select among them
  task automatic obj_write(input logic [15:0] idx, input logic [7:0] d);
    @(posedge clk);
    #10 {obj_wr, obj_index, obj_wdata} = {1'b1, idx, d};
    @(posedge clk);
    #10 {obj_wr, obj_index, obj_wdata} = {1'b0, ~idx, ~d};
  endtask : obj_write
endmodule : fb_master_model

//--- testbench/tb_fbwd_mode.sv
// self-checking bench for the watchdog and operation-mode block
`timescale 1ns/10ps
module tb_fbwd_mode;
  import fbwd_pkg::*;
  logic        clk = 1'b0, nrst = 1'b0, keypad_wr = 1'b0, keypad_mode = 1'b0;
  logic        fault_reset = 1'b0, pdo_assign_wr = 1'b0, ident_wr = 1'b0;
  logic        pdo_rx_profile = 1'b1, pdo_tx_profile = 1'b1;
  logic [31:0] ident_product = '0, ident_revision = '0, vendor_code, product_code, revision_code;
  logic        reg_wr, reg_rd, reg_ack, pd_exchange_ok, obj_wr;
  logic        fieldbus_timeout_fault, op_mode_param, op_mode_monitor, mode_refused;
  logic [11:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, obj_index, m, t, d;
  logic [7:0]  obj_wdata;
  int          error_cnt = 0, n_tests = 0, i, k;

  always #50 clk = ~clk;

  fb_master_model i_fb_master_model (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .pd_exchange_ok(pd_exchange_ok),
    .obj_wr(obj_wr), .obj_index(obj_index), .obj_wdata(obj_wdata));
  fbwd_mode i_fbwd_mode (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .pd_exchange_ok(pd_exchange_ok), .obj_wr(obj_wr), .obj_index(obj_index),
    .obj_wdata(obj_wdata), .pdo_assign_wr(pdo_assign_wr), .pdo_rx_profile(pdo_rx_profile),
    .pdo_tx_profile(pdo_tx_profile), .keypad_wr(keypad_wr), .keypad_mode(keypad_mode),
    .ident_wr(ident_wr), .ident_product(ident_product), .ident_revision(ident_revision),
    .fault_reset(fault_reset), .fieldbus_timeout_fault(fieldbus_timeout_fault),
    .op_mode_param(op_mode_param), .op_mode_monitor(op_mode_monitor),
    .mode_refused(mode_refused), .vendor_code(vendor_code), .product_code(product_code),
    .revision_code(revision_code));

  // clocks from last restart to expiry
  function automatic int wd_limit(input logic [15:0] tm, input logic [15:0] ml);
    return int'(tm) * (int'(ml) + 1);
  endfunction : wd_limit

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic results;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  // read with the answer taken in the ack cycle
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    i_fb_master_model.access(1'b0, a, 16'h0000);
    chk(reg_ack, 1'b1, "ack");
    chk(reg_rdata, e, "read data");
  endtask : rd

  task automatic pulse(ref logic s);
    @(posedge clk);
    #10 s = 1'b1;
    @(posedge clk);
    #10 s = 1'b0;
  endtask : pulse

  task automatic chkm(input logic e, input logic r);
    chk(op_mode_param, e, "mode parameter");
    chk(op_mode_monitor, e, "mode monitor");
    chk(mode_refused, r, "refusal");
  endtask : chkm

  task automatic kp(input logic md);
    keypad_mode = md;
    pulse(keypad_wr);
  endtask : kp

  task automatic pdo(input logic rx, input logic tx);
    {pdo_rx_profile, pdo_tx_profile} = {rx, tx};
    pulse(pdo_assign_wr);
  endtask : pdo

  // hang guard far above the bench's run time
  initial begin
    #9000000;
    error_cnt++;
    results();
  end

  initial begin
    void'($urandom(91746));
    repeat (6) @(posedge clk);
    #10 nrst = 1'b1;
    for (i = 0; i < 3; i++) rd(wd_multiplier_addr + 12'(16 * i), 16'h0000);
    chkm(mode_profile, 1'b0);
    chk(vendor_code, vendor_id_dflt, "vendor");
    chk(product_code, product_code_dflt, "product");
    chk(revision_code, revision_dflt, "revision");
    {ident_product, ident_revision} = {$urandom, $urandom};
    pulse(ident_wr);
    chk(product_code, ident_product, "new product");
    chk(revision_code, ident_revision, "new revision");
    d = 16'($urandom);
    i_fb_master_model.access(1'b1, host_wd_time_addr, d);
    chk(reg_ack, 1'b1, "write ack");
    rd(host_wd_time_addr, d);
    rd(12'h430, 16'h0000);
    for (i = 0; i < 2; i++) begin
      m = 16'($urandom_range(3));
      t = 16'($urandom_range(5, 2));
      i_fb_master_model.set_watchdog(m, t);
      rd(wd_multiplier_addr, m);
      i_fb_master_model.exchange(3 * wd_limit(t, m));
      chk(fieldbus_timeout_fault, 1'b0, "fault under traffic");
      repeat (wd_limit(t, m) - 1) @(posedge clk);
      #10 chk(fieldbus_timeout_fault, 1'b0, "early fault");
      k = 0;
      while (fieldbus_timeout_fault !== 1'b1 && k < 8) begin
        @(posedge clk);
        #10 k++;
      end
      chk(fieldbus_timeout_fault, 1'b1, "no fault");
      if (k == 8) results();
      i_fb_master_model.exchange(1);
      chk(fieldbus_timeout_fault, 1'b1, "fault dropped");
      i_fb_master_model.access(1'b1, pd_wd_time_addr, 16'h0000);
      pulse(fault_reset);
      chk(fieldbus_timeout_fault, 1'b0, "fault kept");
    end
    repeat (60) @(posedge clk);
    #10 chk(fieldbus_timeout_fault, 1'b0, "fault with no time");
    i_fb_master_model.obj_write(mode_select_object, mode_code_bypass);
    chkm(mode_bypass, 1'b0);
    i_fb_master_model.obj_write(mode_select_object, 8'h01);
    chkm(mode_bypass, 1'b0);
    i_fb_master_model.obj_write(16'h6061, mode_code_profile);
    chkm(mode_bypass, 1'b0);
    kp(1'b0);
    chkm(mode_profile, 1'b0);
    kp(1'b1);
    chkm(mode_bypass, 1'b0);
    pdo(1'b1, 1'b1);
    chkm(mode_profile, 1'b0);
    pdo(1'b0, 1'b0);
    chkm(mode_bypass, 1'b0);
    i_fb_master_model.obj_write(mode_select_object, mode_code_profile);
    chkm(mode_bypass, 1'b1);
    kp(1'b0);
    chkm(mode_bypass, 1'b1);
    pdo(1'b1, 1'b1);
    chkm(mode_profile, 1'b0);
    pdo(1'b0, 1'b0);
    chkm(mode_bypass, 1'b0);
    pdo(1'b0, 1'b1);
    chkm(mode_profile, 1'b0);
    pdo(1'b0, 1'b0);
    chkm(mode_bypass, 1'b0);
    pdo(1'b1, 1'b0);
    chkm(mode_profile, 1'b0);
    repeat (6) begin
      k = $urandom_range(1);
      i_fb_master_model.obj_write(mode_select_object, k[0] ? mode_code_bypass : mode_code_profile);
      chkm(k[0], 1'b0);
    end
    results();
  end
endmodule : tb_fbwd_mode
